//--- mic_pkg.sv
// constants, register map and carrier types for the interrupt controller
// assumes a single core clock domain and an apb register port with byte addresses
package mic_pkg;

	localparam int NUM_LINES   = 12;
	localparam int NUM_SOURCES = 15;

	// register byte addresses
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
	localparam logic [7:0] ADDR_EXT_FLAG   = 8'h94;
	localparam logic [7:0] ADDR_BASE_EN    = 8'ha8;
	localparam logic [7:0] ADDR_BASE_LVL   = 8'hb8;
	localparam logic [7:0] ADDR_EXT_CTRL   = 8'hd8;
	localparam logic [7:0] ADDR_EXT_EN     = 8'he8;
	localparam logic [7:0] ADDR_EXT_LVL    = 8'hf8;

	// reset values and bits that read as one
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] ONES_EXT_EN     = 8'he0;
	localparam logic [7:0] ONES_EXT_CTRL   = 8'h40;
	localparam logic [7:0] ONES_EXT_FLAG   = 8'h08;
	localparam logic [7:0] ONES_BASE_LVL   = 8'h80;
	localparam logic [7:0] ONES_EXT_LVL    = 8'he0;

	// writable masks
	localparam logic [7:0] WMASK_BASE_EN   = 8'hff;
	localparam logic [7:0] WMASK_EXT_EN    = 8'h1f;
	localparam logic [7:0] WMASK_EXT_CTRL  = 8'hb8;
	localparam logic [7:0] WMASK_BASE_LVL  = 8'h7f;
	localparam logic [7:0] WMASK_EXT_LVL   = 8'h1f;

	// base enable / base level bit positions
	localparam int B_GLOBAL = 7;
	localparam int B_SER1   = 6;
	localparam int B_SER0   = 4;
	localparam int B_TIM1   = 3;
	localparam int B_EXT1   = 2;
	localparam int B_TIM0   = 1;
	localparam int B_EXT0   = 0;
	// extended enable / extended level bit positions
	localparam int X_CLOCK  = 4;
	localparam int X_TIM3   = 3;
	localparam int X_CONV   = 2;
	localparam int X_TIM2   = 1;
	localparam int X_RADIO  = 0;
	// extended control bits
	localparam int C_BAUD2  = 7;
	localparam int C_FD_EN  = 5;
	localparam int C_FD_FLG = 4;
	localparam int C_CLK_F  = 3;
	// timer control flag bits
	localparam int T_TIM1   = 7;
	localparam int T_TIM0   = 5;
	localparam int T_EXT1   = 3;
	localparam int T_EXT0   = 1;
	// extended flag bits
	localparam int F_TIM3   = 7;
	localparam int F_CONV   = 6;
	localparam int F_TIM2   = 5;
	localparam int F_RADIO  = 4;

	// natural rank of each line
	localparam int L_FLASH = 0;
	localparam int L_EXT0  = 1;
	localparam int L_TIM0  = 2;
	localparam int L_EXT1  = 3;
	localparam int L_TIM1  = 4;
	localparam int L_SER0  = 5;
	localparam int L_SER1  = 6;
	localparam int L_RADIO = 7;
	localparam int L_TIM2  = 8;
	localparam int L_CONV  = 9;
	localparam int L_TIM3  = 10;
	localparam int L_CLOCK = 11;

	localparam logic [7:0] VEC_TABLE [NUM_LINES] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
		8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};

	// service levels
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_HIGH = 2'h1;
	localparam logic [1:0] LVL_TOP  = 2'h2;

	// one-cycle hardware event pulses
	typedef struct packed {
		logic flash_write_done;
		logic trap_executed;
		logic ext0;
		logic timer0;
		logic ext1;
		logic timer1;
		logic radio;
		logic timer2;
		logic timer3;
		logic clock;
	} mic_event_s;

	// flag and local enable levels kept inside peripherals
	typedef struct packed {
		logic serial0_tx_flag;
		logic serial0_rx_flag;
		logic serial1_tx_flag;
		logic serial1_rx_flag;
		logic converter_local_flag;
		logic converter_local_enable;
		logic cipher_local_flag;
		logic cipher_local_enable;
	} mic_periph_s;

	// core instruction boundary
	typedef struct packed {
		logic instr_done;
		logic is_return;
	} mic_core_s;

	// vector fetch to core
	typedef struct packed {
		logic       take;
		logic [7:0] addr;
	} mic_vector_s;

endpackage

//--- mic_ctrl.sv
// interrupt controller: flags, enables, levels, arbitration and vector issue
// assumes apb on pclk, event pulses and core boundary signals synchronous to pclk
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module mic_ctrl #(
	parameter int LINES = mic_pkg::NUM_LINES
) (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// interrupt sources
	input  wire mic_pkg::mic_event_s evt,
	input  wire mic_pkg::mic_periph_s periph,
	// core side
	input  wire mic_pkg::mic_core_s  core,
	output mic_pkg::mic_vector_s     vector,
	output logic [1:0]               active_level,
	output logic                     in_service,
	// peripheral control
	output logic                     serial1_baud_double
);

	initial begin
		if (LINES != mic_pkg::NUM_LINES) begin
			$error("line count must match the fixed vector table");
		end
	end

	logic [7:0] base_en_q, ext_en_q, base_lvl_q, ext_lvl_q;
	logic       baud2_q, fd_en_q, fd_flag_q, clock_flag_q;
	logic       ext0_flag_q, timer0_flag_q, ext1_flag_q, timer1_flag_q;
	logic       radio_flag_q, timer2_flag_q, conv_flag_q, timer3_flag_q;
	logic       hold_q;
	logic [2:0] in_svc_q;
	logic [31:0] prdata_q;
	logic       vec_take_q;
	logic [7:0] vec_addr_q;

	// apb decode; zero wait states
	logic wr, setup, mapped;
	logic [7:0] wdat, rdat;
	assign setup  = psel && !penable;
	assign wr     = psel && penable && pwrite;
	assign wdat   = pwdata[7:0];
	assign pready = 1'b1;
	always_comb begin
		mapped = 1'b1;
		rdat   = 8'h00;
		case (paddr)
			mic_pkg::ADDR_BASE_EN: rdat = base_en_q;
			mic_pkg::ADDR_EXT_EN: rdat = ext_en_q | mic_pkg::ONES_EXT_EN;
			mic_pkg::ADDR_EXT_CTRL: rdat = mic_pkg::ONES_EXT_CTRL | {baud2_q, 1'b0, fd_en_q, fd_flag_q,
				clock_flag_q, 3'h0};
			mic_pkg::ADDR_BASE_LVL: rdat = base_lvl_q | mic_pkg::ONES_BASE_LVL;
			mic_pkg::ADDR_EXT_LVL: rdat = ext_lvl_q | mic_pkg::ONES_EXT_LVL;
			mic_pkg::ADDR_TIMER_CTRL: rdat = {timer1_flag_q, 1'b0, timer0_flag_q, 1'b0, ext1_flag_q, 1'b0,
				ext0_flag_q, 1'b0};
			mic_pkg::ADDR_EXT_FLAG: rdat = mic_pkg::ONES_EXT_FLAG | {timer3_flag_q, conv_flag_q,
				timer2_flag_q, radio_flag_q, 4'h0};
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !mapped;

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= {24'h00_0000, rdat};
		end
	end
	assign prdata = prdata_q;

	logic wr_base_en, wr_ext_en, wr_ext_ctrl, wr_base_lvl, wr_ext_lvl, wr_tctrl, wr_xflag;
	assign wr_base_en  = wr && paddr == mic_pkg::ADDR_BASE_EN;
	assign wr_ext_en   = wr && paddr == mic_pkg::ADDR_EXT_EN;
	assign wr_ext_ctrl = wr && paddr == mic_pkg::ADDR_EXT_CTRL;
	assign wr_base_lvl = wr && paddr == mic_pkg::ADDR_BASE_LVL;
	assign wr_ext_lvl  = wr && paddr == mic_pkg::ADDR_EXT_LVL;
	assign wr_tctrl    = wr && paddr == mic_pkg::ADDR_TIMER_CTRL;
	assign wr_xflag    = wr && paddr == mic_pkg::ADDR_EXT_FLAG;

	// enable, level and control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_en_q  <= mic_pkg::RST_ZERO;
			ext_en_q   <= mic_pkg::RST_ZERO;
			base_lvl_q <= mic_pkg::RST_ZERO;
			ext_lvl_q  <= mic_pkg::RST_ZERO;
			baud2_q    <= 1'b0;
			fd_en_q    <= 1'b0;
		end else begin
			if (wr_base_en) begin
				base_en_q <= wdat & mic_pkg::WMASK_BASE_EN;
			end
			if (wr_ext_en) begin
				ext_en_q <= wdat & mic_pkg::WMASK_EXT_EN;
			end
			if (wr_base_lvl) begin
				base_lvl_q <= wdat & mic_pkg::WMASK_BASE_LVL;
			end
			if (wr_ext_lvl) begin
				ext_lvl_q <= wdat & mic_pkg::WMASK_EXT_LVL;
			end
			if (wr_ext_ctrl) begin
				baud2_q <= wdat[mic_pkg::C_BAUD2];
				fd_en_q <= wdat[mic_pkg::C_FD_EN];
			end
		end
	end
	assign serial1_baud_double = baud2_q;

	// grant bookkeeping shared by the flag logic
	logic       grant;
	logic [3:0] win_line;
	logic [1:0] win_lvl;

	function automatic logic flag_next(input logic cur, input logic hw_set, input logic sw_wr,
		input logic sw_val, input logic hw_clr);
		logic nxt;
		nxt = cur;
		if (sw_wr) begin
			nxt = sw_val;
		end
		if (hw_clr) begin
			nxt = 1'b0;
		end
		// a hardware event in the same cycle as a clear is kept
		if (hw_set) begin
			nxt = 1'b1;
		end
		return nxt;
	endfunction

	logic acc_ext0, acc_tim0, acc_ext1, acc_tim1;
	assign acc_ext0 = grant && win_line == 4'(mic_pkg::L_EXT0);
	assign acc_tim0 = grant && win_line == 4'(mic_pkg::L_TIM0);
	assign acc_ext1 = grant && win_line == 4'(mic_pkg::L_EXT1);
	assign acc_tim1 = grant && win_line == 4'(mic_pkg::L_TIM1);

	// flags; software writes may set them as well as clear them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fd_flag_q     <= 1'b0;
			clock_flag_q  <= 1'b0;
			ext0_flag_q   <= 1'b0;
			timer0_flag_q <= 1'b0;
			ext1_flag_q   <= 1'b0;
			timer1_flag_q <= 1'b0;
			radio_flag_q  <= 1'b0;
			timer2_flag_q <= 1'b0;
			conv_flag_q   <= 1'b0;
			timer3_flag_q <= 1'b0;
		end else begin
			fd_flag_q     <= flag_next(fd_flag_q, evt.flash_write_done || evt.trap_executed, wr_ext_ctrl,
				wdat[mic_pkg::C_FD_FLG], 1'b0);
			clock_flag_q  <= flag_next(clock_flag_q, evt.clock, wr_ext_ctrl, wdat[mic_pkg::C_CLK_F],
				1'b0);
			ext0_flag_q   <= flag_next(ext0_flag_q, evt.ext0, wr_tctrl, wdat[mic_pkg::T_EXT0], acc_ext0);
			timer0_flag_q <= flag_next(timer0_flag_q, evt.timer0, wr_tctrl, wdat[mic_pkg::T_TIM0], acc_tim0);
			ext1_flag_q   <= flag_next(ext1_flag_q, evt.ext1, wr_tctrl, wdat[mic_pkg::T_EXT1], acc_ext1);
			timer1_flag_q <= flag_next(timer1_flag_q, evt.timer1, wr_tctrl, wdat[mic_pkg::T_TIM1], acc_tim1);
			radio_flag_q  <= flag_next(radio_flag_q, evt.radio, wr_xflag, wdat[mic_pkg::F_RADIO], 1'b0);
			timer2_flag_q <= flag_next(timer2_flag_q, evt.timer2, wr_xflag, wdat[mic_pkg::F_TIM2], 1'b0);
			timer3_flag_q <= flag_next(timer3_flag_q, evt.timer3, wr_xflag, wdat[mic_pkg::F_TIM3], 1'b0);
			conv_flag_q   <= flag_next(conv_flag_q, (periph.converter_local_flag && periph.converter_local_enable)
				|| (periph.cipher_local_flag && periph.cipher_local_enable), wr_xflag,
				wdat[mic_pkg::F_CONV], 1'b0);
		end
	end

	// per-line pending, enable and level
	logic [LINES-1:0] line_pend, line_en, line_hi, line_req;
	assign line_pend = {clock_flag_q, timer3_flag_q, conv_flag_q, timer2_flag_q, radio_flag_q,
		periph.serial1_tx_flag || periph.serial1_rx_flag,
		periph.serial0_tx_flag || periph.serial0_rx_flag,
		timer1_flag_q, ext1_flag_q, timer0_flag_q, ext0_flag_q, fd_flag_q};
	assign line_en = {ext_en_q[mic_pkg::X_CLOCK], ext_en_q[mic_pkg::X_TIM3], ext_en_q[mic_pkg::X_CONV],
		ext_en_q[mic_pkg::X_TIM2], ext_en_q[mic_pkg::X_RADIO], base_en_q[mic_pkg::B_SER1],
		base_en_q[mic_pkg::B_SER0], base_en_q[mic_pkg::B_TIM1], base_en_q[mic_pkg::B_EXT1],
		base_en_q[mic_pkg::B_TIM0], base_en_q[mic_pkg::B_EXT0], fd_en_q};
	assign line_hi = {ext_lvl_q[mic_pkg::X_CLOCK], ext_lvl_q[mic_pkg::X_TIM3], ext_lvl_q[mic_pkg::X_CONV],
		ext_lvl_q[mic_pkg::X_TIM2], ext_lvl_q[mic_pkg::X_RADIO], base_lvl_q[mic_pkg::B_SER1],
		base_lvl_q[mic_pkg::B_SER0], base_lvl_q[mic_pkg::B_TIM1], base_lvl_q[mic_pkg::B_EXT1],
		base_lvl_q[mic_pkg::B_TIM0], base_lvl_q[mic_pkg::B_EXT0], 1'b0};

	logic [1:0] line_lvl [LINES];
	for (genvar i = 0; i < LINES; i++) begin : g_line
		if (i == mic_pkg::L_FLASH) begin : g_flash
			assign line_req[i] = line_pend[i] && line_en[i];
			assign line_lvl[i] = mic_pkg::LVL_TOP;
		end else begin : g_norm
			assign line_req[i] = line_pend[i] && line_en[i] && base_en_q[mic_pkg::B_GLOBAL];
			assign line_lvl[i] = line_hi[i] ? mic_pkg::LVL_HIGH : mic_pkg::LVL_LOW;
		end
	end

	// arbitration: highest level, then lowest rank; scanning down lets ties go to the lower rank
	logic found;
	always_comb begin
		found    = 1'b0;
		win_line = 4'h0;
		win_lvl  = mic_pkg::LVL_LOW;
		for (int i = LINES - 1; i >= 0; i--) begin
			if (line_req[i] && (!found || line_lvl[i] >= win_lvl)) begin
				found    = 1'b1;
				win_line = 4'(i);
				win_lvl  = line_lvl[i];
			end
		end
	end

	// current service level from the in-service stack
	logic       busy;
	logic [1:0] cur_lvl;
	always_comb begin
		busy    = |in_svc_q;
		cur_lvl = mic_pkg::LVL_LOW;
		if (in_svc_q[mic_pkg::LVL_TOP]) begin
			cur_lvl = mic_pkg::LVL_TOP;
		end else if (in_svc_q[mic_pkg::LVL_HIGH]) begin
			cur_lvl = mic_pkg::LVL_HIGH;
		end
	end

	// service only at a boundary, never right after a return or an enable/level write
	assign grant = found && (!busy || win_lvl > cur_lvl)
		&& core.instr_done && !core.is_return && !hold_q;

	// a write to an enable or level register delays service by one more instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 1'b0;
		end else if (wr_base_en || wr_ext_en || wr_base_lvl || wr_ext_lvl) begin
			hold_q <= 1'b1;
		end else if (core.instr_done) begin
			hold_q <= 1'b0;
		end
	end

	// nesting: grant pushes its level, return pops the highest one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_svc_q <= 3'h0;
		end else if (grant) begin
			in_svc_q[win_lvl] <= 1'b1;
		end else if (core.instr_done && core.is_return && busy) begin
			in_svc_q[cur_lvl] <= 1'b0;
		end
	end

	// vector issue to the core, one cycle per accepted request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_take_q <= 1'b0;
			vec_addr_q <= 8'h00;
		end else begin
			vec_take_q <= grant;
			if (grant) begin
				vec_addr_q <= mic_pkg::VEC_TABLE[win_line];
			end
		end
	end
	// one driver for the whole struct; per-member continuous assigns are refused by strict tools
	assign vector       = {vec_take_q, vec_addr_q};
	assign active_level = cur_lvl;
	assign in_service   = busy;

endmodule

//--- mic_ctrl_asserts.sv
// port assertions for the interrupt controller
// assumes one pclk domain and presetn active low asynchronous
`timescale 1ns/1ns
module mic_ctrl_asserts (
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// apb
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	// core side and peripheral control
	input wire mic_pkg::mic_core_s   core,
	input wire mic_pkg::mic_vector_s vector,
	input wire logic [1:0]           active_level,
	input wire logic                 in_service,
	input wire logic                 serial1_baud_double
);
	logic wr_hold;
	logic wr_ctrl;
	assign wr_hold = psel && penable && pwrite && paddr inside {8'ha8, 8'he8, 8'hb8, 8'hf8};
	assign wr_ctrl = psel && penable && pwrite && paddr == 8'hd8;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_take_one;
		vector.take |=> !vector.take;
	endproperty
	a_take_one: assert property (p_take_one) else $error("take held too long");
	property p_take_src;
		vector.take |-> $past(core.instr_done) && !$past(core.is_return);
	endproperty
	a_take_src: assert property (p_take_src) else $error("take without boundary");
	property p_ret_hold;
		core.instr_done && core.is_return |=> !vector.take;
	endproperty
	a_ret_hold: assert property (p_ret_hold) else $error("take right after return");
	property p_wr_hold;
		wr_hold && !core.instr_done ##1 core.instr_done |=> !vector.take;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("take right after enable write");
	property p_vec;
		vector.take |-> vector.addr inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h33, 8'h3b, 8'h43, 8'h4b, 8'h53,
			8'h5b, 8'h63};
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_flash_top;
		vector.take && vector.addr == 8'h33 |-> in_service && active_level == mic_pkg::LVL_TOP;
	endproperty
	a_flash_top: assert property (p_flash_top) else $error("flash line not top level");
	property p_preempt;
		vector.take && $past(in_service) |-> active_level > $past(active_level);
	endproperty
	a_preempt: assert property (p_preempt) else $error("preempted by equal or lower");
	property p_ret_low;
		in_service && active_level == mic_pkg::LVL_LOW && core.instr_done && core.is_return |=> !in_service;
	endproperty
	a_ret_low: assert property (p_ret_low) else $error("return left service active");
	property p_baud;
		$past(wr_ctrl) |-> serial1_baud_double == $past(pwdata[7]);
	endproperty
	a_baud: assert property (p_baud) else $error("baud double not written");
endmodule
bind mic_ctrl mic_ctrl_asserts mic_ctrl_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.core, .vector, .active_level, .in_service, .serial1_baud_double);

//--- mic_core_model.sv
// processor core model: instruction boundaries and return instructions
// assumes gap and ret_req come from the bench just after pclk rising edges
`timescale 1ns/1ns
module mic_core_model (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// bench control, gap is cycles between boundaries
	input  wire logic [1:0]    gap,
	input  wire logic          ret_req,
	// core boundary
	output mic_pkg::mic_core_s core
);
	logic [1:0] cnt_q;
	logic       pend_q;
	// a return asked for mid-instruction waits for the next boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 2'h0;
			pend_q <= 1'b0;
			core <= '0;
		end else begin
			core.instr_done <= cnt_q == 2'h0;
			core.is_return <= cnt_q == 2'h0 && (pend_q || ret_req);
			cnt_q <= cnt_q == 2'h0 ? gap : cnt_q - 2'h1;
			pend_q <= cnt_q != 2'h0 && (pend_q || ret_req);
		end
	end
endmodule

//--- mic_tb.sv
// self-checking bench for mic_ctrl: registers, masking, vectors, priority, nesting
// assumes zero wait state apb and the core model as far side
`timescale 1ns/1ns
module testbench;
	logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic                 ret_req = 1'b0, got, serr, pready, pslverr, serial1_baud_double, in_service;
	logic [1:0]           gap = 2'h1, active_level;
	logic [7:0]           paddr = 8'h00, d;
	logic [31:0]          pwdata = 32'h0, prdata, rd;
	mic_pkg::mic_event_s  evt = '0;
	mic_pkg::mic_periph_s periph = '0;
	mic_pkg::mic_core_s   core;
	mic_pkg::mic_vector_s vector;
	int                   err_total = 0, num_checks = 0, seed = 86;
	int                   ev [12] = '{9, 7, 6, 5, 4, 0, 0, 3, 2, 0, 1, 0};
	logic [7:0] pm [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h10, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h00};
	logic [7:0] ea [12] = '{8'hd8, 8'ha8, 8'ha8, 8'ha8, 8'ha8, 8'ha8, 8'ha8, 8'he8, 8'he8, 8'he8, 8'he8, 8'he8};
	logic [7:0] eb [12] = '{8'h20, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
	logic [7:0] fa [12] = '{8'hd8, 8'h88, 8'h88, 8'h88, 8'h88, 8'h88, 8'h88, 8'h94, 8'h94, 8'h94, 8'h94, 8'hd8};
	logic [7:0] fe [12] = '{8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h28, 8'h48, 8'h88, 8'h48};
	logic [7:0] ve [12] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
	logic [7:0] ra [8] = '{8'ha8, 8'he8, 8'hd8, 8'hb8, 8'hf8, 8'h88, 8'h94, 8'h00};
	logic [7:0] re [8] = '{8'h00, 8'he0, 8'h40, 8'h80, 8'he0, 8'h00, 8'h08, 8'h00};
	logic [7:0] wm [4] = '{8'hff, 8'h1f, 8'h7f, 8'h1f};
	mic_ctrl mic_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.evt, .periph, .core, .vector, .active_level, .in_service, .serial1_baud_double);
	mic_core_model mic_core_model_inst (.pclk, .presetn, .gap, .ret_req, .core);
	always #25 pclk = ~pclk;
	task summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// stops at the first take so a nested grant is not skipped
	task take(input logic e, input logic [7:0] a);
		got = 1'b0;
		for (int i = 0; i < 20 && !got; i++) begin
			@(posedge pclk);
			got = vector.take === 1'b1;
		end
		chk("take", e, got);
		if (e) chk("vector", a, vector.addr);
	endtask
	task ret;
		@(posedge pclk);
		ret_req <= 1'b1;
		@(posedge pclk);
		ret_req <= 1'b0;
		got = 1'b0;
		for (int i = 0; i < 20 && !got; i++) begin
			@(posedge pclk);
			got = core.instr_done === 1'b1 && core.is_return === 1'b1;
		end
		@(posedge pclk);
	endtask
	initial begin
		#2000000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, ra[i], 8'h00);
			chk("reset value", re[i], rd);
			chk("slverr", i == 7, serr);
		end
		for (int i = 0; i < 16; i++) begin
			d = 8'($random(seed));
			apb(1'b1, ra[i % 2 * 3 + i / 8], d);
			apb(1'b0, ra[i % 2 * 3 + i / 8], 8'h00);
			chk("register", d & wm[i % 2 * 2 + i / 8] | re[i % 2 * 3 + i / 8], rd);
			apb(1'b1, ra[i % 2 * 3 + i / 8], 8'h00);
		end
		apb(1'b1, 8'hd8, 8'h80);
		@(posedge pclk);
		chk("baud", 1'b1, serial1_baud_double);
		apb(1'b1, 8'hd8, 8'h00);
		for (int l = 0; l < 12; l++) begin
			apb(1'b1, ea[l], eb[l]);
			@(posedge pclk);
			if (pm[l] != 8'h00) periph <= pm[l];
			else evt <= mic_pkg::mic_event_s'(10'h001 << ev[l]);
			@(posedge pclk);
			evt <= '0;
			take(l == 0, ve[l]);
			if (l != 0) begin
				apb(1'b1, 8'ha8, ea[l] == 8'ha8 ? eb[l] | 8'h80 : 8'h80);
				take(1'b1, ve[l]);
			end
			@(posedge pclk);
			periph <= '0;
			apb(1'b0, fa[l], 8'h00);
			chk("flag", fe[l], rd);
			apb(1'b1, fa[l], 8'h00);
			ret();
			take(1'b0, 8'h00);
			apb(1'b1, ea[l], 8'h00);
			apb(1'b1, 8'ha8, 8'h00);
		end
		gap <= 2'h3;
		apb(1'b1, 8'ha8, 8'h8b);
		apb(1'b1, 8'h88, 8'h22);
		take(1'b1, 8'h03);
		ret();
		take(1'b1, 8'h0b);
		ret();
		apb(1'b1, 8'hb8, 8'h02);
		apb(1'b1, 8'h88, 8'h02);
		take(1'b1, 8'h03);
		apb(1'b1, 8'h88, 8'h80);
		take(1'b0, 8'h00);
		apb(1'b1, 8'h88, 8'ha0);
		take(1'b1, 8'h0b);
		chk("level", mic_pkg::LVL_HIGH, active_level);
		ret();
		chk("level", mic_pkg::LVL_LOW, active_level);
		chk("in service", 1'b1, in_service);
		ret();
		take(1'b1, 8'h1b);
		ret();
		chk("idle", 1'b0, in_service);
		summarize();
	end
endmodule
